//--- design/scsd_clock_ctrl.sv
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module scsd_clock_ctrl (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_deep_sleep,
	input wire logic i_main_osc_tick,
	input wire logic i_internal_osc_tick,
	input wire logic i_int_30k_tick,
	input wire logic i_rtc_osc_tick,
	input wire logic i_pll_vco_tick,
	output logic [31:0] o_rd_data,
	output logic o_system_clock_out,
	output logic o_pwm_clk_tick,
	output logic [7:0] o_periph_clk_tick,
	output logic o_main_osc_en,
	output logic o_internal_osc_en,
	output logic o_pll_power_en,
	output logic o_pll_in_use
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0] cfg_primary_ff, nxt_cfg_primary;
	logic [31:0] cfg_extension_ff, nxt_cfg_extension;
	logic [31:0] deep_sleep_cfg_ff, nxt_deep_sleep_cfg;
	logic [7:0] periph_gate_ff, nxt_periph_gate;
	logic [31:0] rd_data_ff, nxt_rd_data;
	logic crystal_change;
	logic [31:0] status_word;

	function automatic logic [2:0] cfg_src(input logic [31:0] word, input logic wide);
		cfg_src = wide ? word[scsd_pkg::POS_OSC_SRC +: 3] : {1'b0, word[scsd_pkg::POS_OSC_SRC +: 2]};
	endfunction

	always_comb begin
		nxt_cfg_primary = cfg_primary_ff;
		nxt_cfg_extension = cfg_extension_ff;
		nxt_deep_sleep_cfg = deep_sleep_cfg_ff;
		nxt_periph_gate = periph_gate_ff;
		nxt_rd_data = 32'h0000_0000;
		crystal_change = 1'b0;
		if (i_wr && i_addr == scsd_pkg::ADDR_CFG_PRIMARY) begin
			nxt_cfg_primary = i_wr_data;
			// Rewriting the same crystal value must not restart the relock wait.
			crystal_change = i_wr_data[scsd_pkg::POS_CRYSTAL +: 5] != cfg_primary_ff[scsd_pkg::POS_CRYSTAL +: 5];
		end else if (i_wr && i_addr == scsd_pkg::ADDR_CFG_EXTENSION) begin
			nxt_cfg_extension = i_wr_data;
		end else if (i_wr && i_addr == scsd_pkg::ADDR_DEEP_SLEEP_CFG) begin
			nxt_deep_sleep_cfg = i_wr_data;
		end else if (i_wr && i_addr == scsd_pkg::ADDR_PERIPH_GATE) begin
			nxt_periph_gate = i_wr_data[7:0];
		end
		if (i_rd && i_addr == scsd_pkg::ADDR_CFG_PRIMARY) begin
			nxt_rd_data = cfg_primary_ff;
		end else if (i_rd && i_addr == scsd_pkg::ADDR_CFG_EXTENSION) begin
			nxt_rd_data = cfg_extension_ff;
		end else if (i_rd && i_addr == scsd_pkg::ADDR_DEEP_SLEEP_CFG) begin
			nxt_rd_data = deep_sleep_cfg_ff;
		end else if (i_rd && i_addr == scsd_pkg::ADDR_PERIPH_GATE) begin
			nxt_rd_data = {24'h00_0000, periph_gate_ff};
		end else if (i_rd && i_addr == scsd_pkg::ADDR_STATUS) begin
			nxt_rd_data = status_word;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_primary_ff <= scsd_pkg::RST_CFG_PRIMARY;
			cfg_extension_ff <= scsd_pkg::RST_CFG_EXTENSION;
			deep_sleep_cfg_ff <= scsd_pkg::RST_DEEP_SLEEP_CFG;
			periph_gate_ff <= scsd_pkg::RST_PERIPH_GATE;
			rd_data_ff <= 32'h0000_0000;
		end else begin
			cfg_primary_ff <= nxt_cfg_primary;
			cfg_extension_ff <= nxt_cfg_extension;
			deep_sleep_cfg_ff <= nxt_deep_sleep_cfg;
			periph_gate_ff <= nxt_periph_gate;
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign o_rd_data = rd_data_ff;

	// ------------------------------------------------------------
	// Effective configuration
	// ------------------------------------------------------------
	scsd_pkg::scsd_clk_cfg_type eff;
	logic override;
	logic dslp_active;

	always_comb begin
		override = cfg_extension_ff[scsd_pkg::POS_OVERRIDE];
		dslp_active = i_deep_sleep && deep_sleep_cfg_ff[scsd_pkg::POS_DSLP_USE];
		eff.use_system_divider_field = cfg_primary_ff[scsd_pkg::POS_USE_SYSTEM_DIVIDER_FIELD];
		if (override) begin
			eff.src = cfg_src(cfg_extension_ff, 1'b1);
			eff.bypass = cfg_extension_ff[scsd_pkg::POS_BYPASS];
			eff.pll_pwrdn = cfg_extension_ff[scsd_pkg::POS_PLL_PWRDN];
			eff.system_divider_field = cfg_extension_ff[scsd_pkg::POS_SYSTEM_DIVIDER_FIELD +: 6];
		end else begin
			eff.src = cfg_src(cfg_primary_ff, 1'b0);
			eff.bypass = cfg_primary_ff[scsd_pkg::POS_BYPASS];
			eff.pll_pwrdn = cfg_primary_ff[scsd_pkg::POS_PLL_PWRDN];
			eff.system_divider_field = {2'b00, cfg_primary_ff[scsd_pkg::POS_SYSTEM_DIVIDER_FIELD +: 4]};
		end
		if (dslp_active) begin
			eff.src = cfg_src(deep_sleep_cfg_ff, 1'b1);
			eff.system_divider_field = deep_sleep_cfg_ff[scsd_pkg::POS_SYSTEM_DIVIDER_FIELD +: 6];
		end
	end

	// ------------------------------------------------------------
	// PLL relock tracking
	// ------------------------------------------------------------
	scsd_pkg::scsd_pll_state_type pll_state_ff, nxt_pll_state;
	logic [12:0] relock_cnt_ff, nxt_relock_cnt;

	always_comb begin
		nxt_pll_state = pll_state_ff;
		nxt_relock_cnt = relock_cnt_ff;
		case (pll_state_ff)
			scsd_pkg::PLL_OFF: begin
				if (!eff.pll_pwrdn) begin
					nxt_pll_state = scsd_pkg::PLL_RELOCK;
					nxt_relock_cnt = scsd_pkg::RELOCK_LOAD;
				end
			end
			scsd_pkg::PLL_RELOCK: begin
				if (eff.pll_pwrdn) begin
					nxt_pll_state = scsd_pkg::PLL_OFF;
				end else if (crystal_change) begin
					nxt_relock_cnt = scsd_pkg::RELOCK_LOAD;
				end else if (i_main_osc_tick && relock_cnt_ff == 13'h0000) begin
					nxt_pll_state = scsd_pkg::PLL_LOCKED;
				end else if (i_main_osc_tick) begin
					nxt_relock_cnt = relock_cnt_ff - 13'h0001;
				end
			end
			scsd_pkg::PLL_LOCKED: begin
				if (eff.pll_pwrdn) begin
					nxt_pll_state = scsd_pkg::PLL_OFF;
				end else if (crystal_change) begin
					nxt_pll_state = scsd_pkg::PLL_RELOCK;
					nxt_relock_cnt = scsd_pkg::RELOCK_LOAD;
				end
			end
			default: begin
				nxt_pll_state = scsd_pkg::PLL_OFF;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pll_state_ff <= scsd_pkg::PLL_OFF;
			relock_cnt_ff <= 13'h0000;
		end else begin
			pll_state_ff <= nxt_pll_state;
			relock_cnt_ff <= nxt_relock_cnt;
		end
	end

	// ------------------------------------------------------------
	// Source selection and dividers
	// ------------------------------------------------------------
	logic pll_path;
	logic src_tick;
	logic sys_tick;
	logic pwm_tick;
	logic [5:0] sys_tc;
	logic [5:0] pwm_tc;
	logic vco_half_ff, nxt_vco_half;
	logic [1:0] internal_osc_div_ff, nxt_internal_osc_div;
	logic [5:0] div_cnt_ff, nxt_div_cnt;
	logic [5:0] pwm_cnt_ff, nxt_pwm_cnt;
	logic sys_tick_ff, pwm_tick_ff, pll_use_ff;
	logic [7:0] periph_tick_ff;

	function automatic logic [5:0] pwm_terminal(input logic [2:0] code);
		// Codes above five saturate at the largest ratio.
		pwm_terminal = (code > 3'h5) ? 6'h3F : 6'((7'h02 << code) - 7'h01);
	endfunction

	always_comb begin
		// A PLL that is still relocking is never used; the oscillator keeps running the system.
		pll_path = !eff.bypass && eff.src == scsd_pkg::SRC_MAIN &&
			pll_state_ff == scsd_pkg::PLL_LOCKED;
		nxt_vco_half = vco_half_ff ^ i_pll_vco_tick;
		nxt_internal_osc_div = internal_osc_div_ff + {1'b0, i_internal_osc_tick};
		if (pll_path) begin
			src_tick = i_pll_vco_tick && vco_half_ff;
		end else begin
			case (eff.src)
				scsd_pkg::SRC_MAIN: src_tick = i_main_osc_tick;
				scsd_pkg::SRC_INTERNAL_DIV4: src_tick = i_internal_osc_tick && internal_osc_div_ff == 2'h3;
				scsd_pkg::SRC_INT_30K: src_tick = i_int_30k_tick;
				scsd_pkg::SRC_RTC: src_tick = i_rtc_osc_tick;
				default: src_tick = i_internal_osc_tick;
			endcase
		end
		if (pll_path || eff.use_system_divider_field) begin
			// Encoding 0 still divides by two; with the PLL codes below three are reserved.
			sys_tc = (eff.system_divider_field == 6'h00) ? 6'h01 : eff.system_divider_field;
		end else begin
			sys_tc = 6'h00;
		end
		sys_tick = src_tick && div_cnt_ff >= sys_tc;
		nxt_div_cnt = div_cnt_ff;
		if (sys_tick) begin
			nxt_div_cnt = 6'h00;
		end else if (src_tick) begin
			nxt_div_cnt = div_cnt_ff + 6'h01;
		end
		pwm_tc = cfg_primary_ff[scsd_pkg::POS_USE_PWM_DIV] ?
			pwm_terminal(cfg_primary_ff[scsd_pkg::POS_PWM_DIV +: 3]) : 6'h00;
		pwm_tick = sys_tick && pwm_cnt_ff >= pwm_tc;
		nxt_pwm_cnt = pwm_cnt_ff;
		if (pwm_tick) begin
			nxt_pwm_cnt = 6'h00;
		end else if (sys_tick) begin
			nxt_pwm_cnt = pwm_cnt_ff + 6'h01;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			vco_half_ff <= 1'b0;
			internal_osc_div_ff <= 2'h0;
			div_cnt_ff <= 6'h00;
			pwm_cnt_ff <= 6'h00;
			sys_tick_ff <= 1'b0;
			pwm_tick_ff <= 1'b0;
			pll_use_ff <= 1'b0;
			periph_tick_ff <= 8'h00;
		end else begin
			vco_half_ff <= nxt_vco_half;
			internal_osc_div_ff <= nxt_internal_osc_div;
			div_cnt_ff <= nxt_div_cnt;
			pwm_cnt_ff <= nxt_pwm_cnt;
			sys_tick_ff <= sys_tick;
			pwm_tick_ff <= pwm_tick;
			pll_use_ff <= pll_path;
			periph_tick_ff <= {8{sys_tick}} & periph_gate_ff;
		end
	end

	// ------------------------------------------------------------
	// Enables and status
	// ------------------------------------------------------------
	logic main_en_ff, int_en_ff, pll_en_ff;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			main_en_ff <= 1'b0;
			int_en_ff <= 1'b1;
			pll_en_ff <= 1'b0;
		end else begin
			main_en_ff <= !cfg_primary_ff[scsd_pkg::POS_MAIN_OSC_DIS];
			int_en_ff <= !cfg_primary_ff[scsd_pkg::POS_INT_OSC_DIS];
			pll_en_ff <= !eff.pll_pwrdn;
		end
	end

	assign status_word = {16'h0000, relock_cnt_ff[12:0], pll_use_ff, pll_state_ff == scsd_pkg::PLL_LOCKED, 1'b0};
	assign o_system_clock_out = sys_tick_ff;
	assign o_pwm_clk_tick = pwm_tick_ff;
	assign o_periph_clk_tick = periph_tick_ff;
	assign o_main_osc_en = main_en_ff;
	assign o_internal_osc_en = int_en_ff;
	assign o_pll_power_en = pll_en_ff;
	assign o_pll_in_use = pll_use_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	sequence relock_starts;
		pll_state_ff == scsd_pkg::PLL_OFF && !eff.pll_pwrdn;
	endsequence

	sequence relock_loaded;
		pll_state_ff == scsd_pkg::PLL_RELOCK && relock_cnt_ff == scsd_pkg::RELOCK_LOAD;
	endsequence

	relock_load_a: assert property (relock_starts |=> relock_loaded)
		else $error("relock counter not loaded on PLL power-up");
	relock_step_a: assert property (pll_state_ff == scsd_pkg::PLL_RELOCK && !eff.pll_pwrdn && !crystal_change &&
		i_main_osc_tick && relock_cnt_ff != 13'h0000 |=> relock_cnt_ff == $past(relock_cnt_ff) - 13'h0001)
		else $error("relock counter did not step on main tick");
	pll_gated_a: assert property (o_pll_in_use |-> $past(pll_state_ff) == scsd_pkg::PLL_LOCKED)
		else $error("PLL used before relock completed");
	pll_source_a: assert property (o_pll_in_use |-> $past(eff.src) == scsd_pkg::SRC_MAIN && !$past(eff.bypass))
		else $error("PLL used without main oscillator path");
	sys_divide_a: assert property (src_tick && div_cnt_ff >= sys_tc |=> o_system_clock_out)
		else $error("system clock tick missing at terminal count");
	sys_quiet_a: assert property (!src_tick |=> !o_system_clock_out)
		else $error("system clock tick without source tick");
	pwm_sync_a: assert property (o_pwm_clk_tick |-> o_system_clock_out)
		else $error("PWM tick not aligned to system tick");
	gate_enable_a: assert property ((o_periph_clk_tick & ~$past(periph_gate_ff)) == 8'h00)
		else $error("peripheral clock ticked while disabled");
	override_use_a: assert property (override && !dslp_active |->
		eff.src == cfg_extension_ff[scsd_pkg::POS_OSC_SRC +: 3])
		else $error("extension source not used under override");
	rtc_select_a: assert property (!pll_path && eff.src == scsd_pkg::SRC_RTC |-> src_tick == i_rtc_osc_tick)
		else $error("real-time oscillator not selected");

endmodule

//--- design/scsd_pkg.sv
// Notes on behaviour
// - System clock runs from the internal oscillator during and after reset until changed.
// - PLL output and internal oscillator divided by four are extra clock candidates.
// - In bypass the source field picks main, internal, internal/4 or 30 kHz.
// - Only the main oscillator feeds the PLL; other sources are used whether or not bypass is set.
// - Real-time oscillator is selected by extended source 0x7, with or without bypass.
// - Override bit makes the extension fields replace the primary fields.
// - PWM clock is a synchronous division of the system clock by the PWM field.
// - Every peripheral clock comes from the system clock with its own enable.
// - System divider applies to PLL output or selected oscillator per bypass.
// - With the PLL, the VCO output is halved before the system divisor.
// - Divisor equals the system divider encoding plus one, except encoding 0, which divides by two.
// - Registers hold sleep sources, source, enables, divisors and crystal selection.
// - In deep sleep the source and divider may come from the deep-sleep register.
// - Crystal change or PLL power-up loads a 0x1200 relock counter on main ticks.
// - Enabled and selected together, the PLL is used only after relock completes.
package scsd_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG_PRIMARY = 8'h00;
	localparam logic [7:0] ADDR_CFG_EXTENSION = 8'h04;
	localparam logic [7:0] ADDR_DEEP_SLEEP_CFG = 8'h08;
	localparam logic [7:0] ADDR_PERIPH_GATE = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int POS_MAIN_OSC_DIS = 0;
	localparam int POS_INT_OSC_DIS = 1;
	localparam int POS_OSC_SRC = 4;
	localparam int POS_CRYSTAL = 6;
	localparam int POS_BYPASS = 11;
	localparam int POS_PLL_PWRDN = 13;
	localparam int POS_PWM_DIV = 17;
	localparam int POS_USE_PWM_DIV = 20;
	localparam int POS_USE_SYSTEM_DIVIDER_FIELD = 22;
	localparam int POS_SYSTEM_DIVIDER_FIELD = 23;
	localparam int POS_OVERRIDE = 31;
	localparam int POS_DSLP_USE = 0;

	// ------------------------------------------------------------
	// Reset values and constants
	// ------------------------------------------------------------
	localparam logic [31:0] RST_CFG_PRIMARY = 32'h07C0_2C10;
	localparam logic [31:0] RST_CFG_EXTENSION = 32'h07C0_2810;
	localparam logic [31:0] RST_DEEP_SLEEP_CFG = 32'h0780_0000;
	localparam logic [7:0] RST_PERIPH_GATE = 8'h00;
	localparam logic [12:0] RELOCK_LOAD = 13'h1200;
	localparam logic [2:0] SRC_MAIN = 3'h0;
	localparam logic [2:0] SRC_INTERNAL = 3'h1;
	localparam logic [2:0] SRC_INTERNAL_DIV4 = 3'h2;
	localparam logic [2:0] SRC_INT_30K = 3'h3;
	localparam logic [2:0] SRC_RTC = 3'h7;
	localparam logic [5:0] PLL_MIN_SYSTEM_DIVIDER_FIELD = 6'h03;

	typedef struct packed {
		logic [2:0] src;
		logic bypass;
		logic pll_pwrdn;
		logic use_system_divider_field;
		logic [5:0] system_divider_field;
	} scsd_clk_cfg_type;

	typedef enum logic [2:0] {
		PLL_OFF = 3'b001,
		PLL_RELOCK = 3'b010,
		PLL_LOCKED = 3'b100
	} scsd_pll_state_type;

endpackage

//--- dv/system_clock_source_divider_tb.sv
`timescale 1ns/1ps
module system_clock_source_divider_tb;
	// ----------------------------------------
	// Stimulus, model state and design
	// ----------------------------------------
	logic i_core_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_deep_sleep = 1'b0;
	logic [4:0] tk = 5'h00;
	logic [31:0] o_rd_data;
	logic o_system_clock_out, o_pwm_clk_tick, o_main_osc_en, o_internal_osc_en, o_pll_power_en, o_pll_in_use;
	logic [7:0] o_periph_clk_tick;
	logic [7:0] g_last = 8'h00;
	logic [31:0] regs [4];
	logic [31:0] mask [4] = '{32'h07DE2FF3, 32'h9F802870, 32'h1F800071, 32'h000000FF};
	int err_count = 0, num_checks = 0, cycles = 0, seed = 32'h9065a616;
	int arm = 0, parm = 0, cnt = 0, pcnt = 0, n_sys = 0, n_pwm = 0;
	bit force_main = 0, hold = 0, pll_ok = 0;
	scsd_clock_ctrl dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
		.i_wr(i_wr), .i_rd(i_rd), .i_deep_sleep(i_deep_sleep), .i_main_osc_tick(tk[0]), .i_internal_osc_tick(tk[1]),
		.i_int_30k_tick(tk[2]), .i_rtc_osc_tick(tk[3]), .i_pll_vco_tick(tk[4]), .o_rd_data(o_rd_data),
		.o_system_clock_out(o_system_clock_out), .o_pwm_clk_tick(o_pwm_clk_tick), .o_periph_clk_tick(o_periph_clk_tick),
		.o_main_osc_en(o_main_osc_en), .o_internal_osc_en(o_internal_osc_en), .o_pll_power_en(o_pll_power_en),
		.o_pll_in_use(o_pll_in_use));
	always #50 i_core_clk = ~i_core_clk;
	// Oscillator edges arrive at random; the main one is held busy while the relock count runs.
	always @(posedge i_core_clk) begin
		tk <= 5'($random(seed)) | {4'h0, force_main};
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(string what, logic exp, logic got);
		chk_word(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic chk_count(string what, int exp, int got);
		chk_word(what, 32'(exp), 32'(got));
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		if (a <= 8'h0C && a[1:0] == 2'h0) regs[a[3:2]] = d & mask[a[3:2]];
		arm = 0;
		parm = 0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] v);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		v = o_rd_data;
		@(negedge i_core_clk);
		chk_word("rd_idle", 32'h00000000, o_rd_data);
	endtask
	task automatic wait_res(int n, bit pwm);
		int goal;
		goal = (pwm ? n_pwm : n_sys) + n;
		for (int c = 0; c < 20000 && (pwm ? n_pwm : n_sys) < goal; c++) @(posedge i_core_clk);
		chk_bit("progress", 1'b1, (pwm ? n_pwm : n_sys) >= goal);
	endtask
	task automatic chk_en();
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk_bit("main_en", ~regs[0][0], o_main_osc_en);
		chk_bit("int_en", ~regs[0][1], o_internal_osc_en);
		chk_bit("pll_pwr", ~(regs[1][31] ? regs[1][13] : regs[0][13]), o_pll_power_en);
	endtask
	// Reference divider: which source edge feeds the system clock and how many edges make one period.
	function automatic void expect_clk(output int sel, output int div);
		int src, sd;
		bit byp, pd;
		src = regs[1][31] ? int'(regs[1][6:4]) : int'(regs[0][5:4]);
		byp = regs[1][31] ? regs[1][11] : regs[0][11];
		pd = regs[1][31] ? regs[1][13] : regs[0][13];
		sd = regs[1][31] ? int'(regs[1][28:23]) : int'(regs[0][26:23]);
		if (i_deep_sleep && regs[2][0]) begin
			src = int'(regs[2][6:4]);
			sd = int'(regs[2][28:23]);
		end
		sel = src == 0 ? 0 : src == 3 ? 2 : src == 7 ? 3 : 1;
		div = !regs[0][22] ? 1 : (sd == 0 ? 2 : sd + 1);
		if (src == 2) div = div * 4;
		if (!byp && src == 0 && !pd && pll_ok) begin
			sel = 4;
			div = 2 * (sd + 1);
		end
	endfunction
	// Whole periods only: the two pulses after any change may carry a partial count.
	always @(negedge i_core_clk) begin
		int sel, div, pdiv;
		if (i_arst_n) begin
			expect_clk(sel, div);
			pdiv = !regs[0][20] ? 1 : (regs[0][19:17] >= 3'h6 ? 64 : 2 << regs[0][19:17]);
			if (hold) arm = 0;
			chk_word("periph", o_system_clock_out ? {24'h0, g_last} : 32'h0, {24'h0, o_periph_clk_tick});
			chk_bit("pwm_sub", 1'b0, o_pwm_clk_tick & ~o_system_clock_out);
			if (o_system_clock_out === 1'b1) begin
				if (arm >= 2) chk_count("sys_div", div, cnt);
				if (arm >= 2) n_sys++;
				arm++;
				cnt = 0;
				pcnt++;
				if (o_pwm_clk_tick === 1'b1) begin
					if (parm >= 2) chk_count("pwm_div", pdiv, pcnt);
					if (parm >= 2) n_pwm++;
					parm++;
					pcnt = 0;
				end
			end
			g_last = regs[3][7:0];
			if (tk[sel] === 1'b1) cnt++;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] v;
		regs = '{scsd_pkg::RST_CFG_PRIMARY, scsd_pkg::RST_CFG_EXTENSION, scsd_pkg::RST_DEEP_SLEEP_CFG, 32'h00000000};
		repeat (20) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		for (int a = 0; a < 4; a++) begin
			rd(8'(a * 4), v);
			chk_word("reset_val", regs[a] & mask[a], v & mask[a]);
		end
		chk_en();
		wait_res(3, 0);
		wr(8'h40, 32'($random(seed)));
		rd(8'h40, v);
		chk_word("unmapped", 32'h00000000, v);
		$display("test reset_and_bus done");
		for (int n = 0; n < 10; n++) begin
			v = 32'h00402C00 | (32'($random(seed)) & 32'h001E0000) | 32'(n & 1);
			v = v | (32'(n < 4 ? n : $random(seed) & 3) << 4);
			v = v | (32'(n == 4 ? 0 : n == 5 ? 15 : $random(seed) & 15) << 23);
			if (n == 9) v[22] = 1'b0;
			wr(scsd_pkg::ADDR_PERIPH_GATE, 32'($random(seed)));
			wr(scsd_pkg::ADDR_CFG_PRIMARY, v);
			chk_en();
			wait_res(3, 0);
		end
		$display("test bypass_sources done");
		for (int c = 0; c < 8; c++) begin
			wr(scsd_pkg::ADDR_CFG_PRIMARY, 32'h00502C00 | (32'(c) << 17));
			wait_res(2, 1);
		end
		$display("test pwm_ratio done");
		wr(scsd_pkg::ADDR_CFG_EXTENSION, 32'h9F802870);
		wait_res(3, 0);
		wr(scsd_pkg::ADDR_CFG_EXTENSION, 32'h82802820);
		wait_res(3, 0);
		wr(scsd_pkg::ADDR_CFG_EXTENSION, scsd_pkg::RST_CFG_EXTENSION);
		wr(scsd_pkg::ADDR_DEEP_SLEEP_CFG, 32'h03000031);
		i_deep_sleep <= 1'b1;
		wait_res(3, 0);
		wr(scsd_pkg::ADDR_DEEP_SLEEP_CFG, 32'h03000030);
		wait_res(3, 0);
		i_deep_sleep <= 1'b0;
		$display("test override_and_sleep done");
		force_main = 1;
		wr(scsd_pkg::ADDR_CFG_PRIMARY, 32'h02400400);
		chk_en();
		repeat (4000) @(posedge i_core_clk);
		@(negedge i_core_clk);
		hold = 1;
		chk_bit("pll_use", 1'b0, o_pll_in_use);
		repeat (700) @(posedge i_core_clk);
		@(negedge i_core_clk);
		pll_ok = 1;
		hold = 0;
		chk_bit("pll_use", 1'b1, o_pll_in_use);
		rd(scsd_pkg::ADDR_STATUS, v);
		chk_word("status", 32'h00000006, v & 32'h00000006);
		wait_res(3, 0);
		wr(scsd_pkg::ADDR_CFG_PRIMARY, 32'h02400440);
		hold = 1;
		pll_ok = 0;
		repeat (4) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk_bit("relock", 1'b0, o_pll_in_use);
		repeat (4700) @(posedge i_core_clk);
		@(negedge i_core_clk);
		pll_ok = 1;
		hold = 0;
		chk_bit("relock", 1'b1, o_pll_in_use);
		wr(scsd_pkg::ADDR_CFG_PRIMARY, 32'h02400440);
		repeat (10) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk_bit("same_crystal_select_field", 1'b1, o_pll_in_use);
		wait_res(3, 0);
		$display("test pll_relock done");
		tally_and_finish();
	end
endmodule
